// [include/serial_regs_pkg.sv]
// constants, types and register layout of the serial register interface
// Behaviour
// - receive-full flag with receive interrupt enable requests an interrupt; enable resets to 0
// - master select 1 means master, 0 slave; resets to master
// - polarity sets clock idle level, resets 0; phase resets 1; both ends must match
// - slave with phase 0 starts on select falling edge, driving its top bit
// - no new transmit data enters an active slave shifter; load before start
// - slave with phase 1 starts on the first serial clock edge
// - slave deselected: data-out floats, serial clocks ignored, state machine otherwise untouched
// - wired-or bit makes clock and data pins open-drain, else push-pull
// - enable bit activates the block, resets 0; clearing it partially resets
// - transmit-empty flag with transmit interrupt enable requests an interrupt; enable resets 0
// - receive-full sets on each received byte; any data read clears it
// - error interrupt enable lets overflow or mode fault request an interrupt
// - byte arriving while receive buffer unread sets overflow; old byte kept
// - overflow clears after status read seeing it, then data read
// - mode fault: slave select rising mid-transfer, or master select going low
// - mode fault clears after status read seeing it, then data write
// - transmit-empty sets on shifter load, resets 1; idle load within two cycles
// - mode fault enable permits the flag; clearing enable keeps a set flag
// - fault detection off: master ignores select; slave neither sets the flag nor aborts the byte
// - master rate codes pick divisor 2, 8, 32, 128; clock is base over twice
// - data writes fill the transmit buffer, reads return the separate receive buffer
package serial_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_DATA    = 8'h12;

  // control register fields
  localparam int CTL_RX_IRQ_EN  = 7;
  localparam int CTL_MASTER     = 5;
  localparam int CTL_POLARITY   = 4;
  localparam int CTL_PHASE      = 3;
  localparam int CTL_WIRED_OR   = 2;
  localparam int CTL_ENABLE     = 1;
  localparam int CTL_TX_IRQ_EN  = 0;

  // status/control register fields
  localparam int STS_RX_FULL    = 7;
  localparam int STS_ERR_IRQ_EN = 6;
  localparam int STS_OVERFLOW   = 5;
  localparam int STS_MODE_FAULT = 4;
  localparam int STS_TX_EMPTY   = 3;
  localparam int STS_MF_ENABLE  = 2;
  localparam int STS_RATE_HI    = 1;
  localparam int STS_RATE_LO    = 0;

  // reset values of the master and phase control bits and the transmit-empty flag
  localparam logic RST_MASTER   = 1'b1;
  localparam logic RST_PHASE    = 1'b1;
  localparam logic RST_TX_EMPTY = 1'b1;

  // master rate divisors in system clock cycles per half period; code 3 runs one cycle over RATE_DIV_3
  localparam logic [6:0] RATE_DIV_0 = 7'h02;
  localparam logic [6:0] RATE_DIV_1 = 7'h08;
  localparam logic [6:0] RATE_DIV_2 = 7'h20;
  localparam logic [6:0] RATE_DIV_3 = 7'h7f;
  localparam logic       RATE_3_EXTRA = 1'b1;

  // last clock edge of one byte, counting from 0
  localparam logic [3:0] LAST_EDGE = 4'hf;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } xfer_state_t;

  // one output pin: driven level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// [design/serial_regs.sv]
// byte serial interface: register port, master clock generator, shifter and flags
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module serial_regs
  import serial_regs_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata_reg,
  // interrupt request
  output logic                   irq_reg,
  // serial pins
  input  wire logic              sclk_in,
  input  wire logic              mosi_in,
  input  wire logic              miso_in,
  input  wire logic              ss_n_in,
  output pin_drive_t             sclk_drv_reg,
  output pin_drive_t             mosi_drv_reg,
  output pin_drive_t             miso_drv_reg
);

  // control bits
  logic              rx_irq_enable;
  logic              master_select;
  logic              clock_polarity;
  logic              clock_phase;
  logic              wired_or_select;
  logic              serial_enable;
  logic              tx_irq_enable;
  logic              error_irq_enable;
  logic              mode_fault_enable;
  logic              rate_select_hi;
  logic              rate_select_lo;
  // flags
  logic              rx_full_flag;
  logic              overflow_flag;
  logic              mode_fault_flag;
  logic              tx_empty_flag;
  logic              ovr_armed_reg;
  logic              mf_armed_reg;
  // buffers and shifter
  logic [DATA_W-1:0] tx_buf_reg;
  logic [DATA_W-1:0] rx_buf_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic [DATA_W-1:0] rx_shift_reg;
  logic [3:0]        edge_cnt_reg;
  xfer_state_t       state_reg;
  // clocking
  logic [6:0]        div_cnt_reg;
  logic              sclk_level_reg;
  logic              sclk_prev_reg;
  logic              ss_prev_reg;

  // strobes
  logic              wr_ctl;
  logic              wr_sts;
  logic              wr_data;
  logic              rd_sts;
  logic              rd_data;
  logic              is_master;
  logic              is_slave;
  logic              selected;
  logic              sclk_edge;
  logic              lead_edge;
  logic              trail_edge;
  logic              sample_edge;
  logic              shift_edge;
  logic              start_xfer;
  logic              load_shift;
  logic              byte_done;
  logic              master_fault;
  logic              slave_fault;
  logic              div_tick;
  logic              data_bit_in;
  logic [DATA_W-1:0] rx_byte;
  logic [6:0]        half_period;

  // half period of the master clock in system cycles, minus one
  function automatic logic [6:0] rate_divisor(input logic hi, input logic lo);
    logic [6:0] d;
    d = RATE_DIV_0;
    case ({hi, lo})
      2'b00:   d = RATE_DIV_0 - 7'h01;
      2'b01:   d = RATE_DIV_1 - 7'h01;
      2'b10:   d = RATE_DIV_2 - 7'h01;
      2'b11:   d = RATE_DIV_3 - 7'(RATE_3_EXTRA) + 7'h01;
      default: d = RATE_DIV_0 - 7'h01;
    endcase
    return d;
  endfunction

  // push-pull or open-drain drive of one pin
  function automatic pin_drive_t pin_drive(input logic level, input logic en, input logic wired);
    pin_drive_t p;
    p.out = wired ? 1'b0 : level;
    p.oe  = wired ? (en & ~level) : en;
    return p;
  endfunction

  assign wr_ctl  = wr && (addr == OFS_CONTROL);
  assign wr_sts  = wr && (addr == OFS_STATUS);
  assign wr_data = wr && (addr == OFS_DATA);
  assign rd_sts  = rd && (addr == OFS_STATUS);
  assign rd_data = rd && (addr == OFS_DATA);

  assign is_master = serial_enable & master_select;
  assign is_slave  = serial_enable & ~master_select;
  assign selected  = is_slave & ~ss_n_in;
  assign half_period = rate_divisor(rate_select_hi, rate_select_lo);
  assign div_tick  = is_master && (state_reg == ST_RUN) && (div_cnt_reg == '0);

  // edges: generated by the divider as master, seen on the pin as slave
  always_comb begin
    sclk_edge  = 1'b0;
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    if (is_master && div_tick) begin
      sclk_edge  = 1'b1;
      lead_edge  = (sclk_level_reg == clock_polarity);
      trail_edge = (sclk_level_reg != clock_polarity);
    end else if (selected && (sclk_in != sclk_prev_reg)) begin
      sclk_edge  = 1'b1;
      lead_edge  = (sclk_in != clock_polarity);
      trail_edge = (sclk_in == clock_polarity);
    end
  end

  assign sample_edge = clock_phase ? trail_edge : lead_edge;
  assign shift_edge  = clock_phase ? lead_edge : trail_edge;
  assign data_bit_in = master_select ? miso_in : mosi_in;
  assign rx_byte     = clock_phase ? {rx_shift_reg[DATA_W-2:0], data_bit_in} : rx_shift_reg;

  // start of a byte
  always_comb begin
    start_xfer = 1'b0;
    if (state_reg == ST_IDLE) begin
      if (is_master)
        start_xfer = ~tx_empty_flag & ~master_fault;
      else if (is_slave && !clock_phase)
        start_xfer = ss_prev_reg & ~ss_n_in;
      else if (is_slave)
        start_xfer = sclk_edge;
    end
  end

  // an idle end moves a pending byte into the shifter; never while running
  assign load_shift = (state_reg == ST_IDLE) && serial_enable && !tx_empty_flag;
  assign byte_done  = (state_reg == ST_RUN) && sclk_edge && (edge_cnt_reg == LAST_EDGE);

  // select low on a master, or rising mid-byte on a slave
  assign master_fault = is_master & mode_fault_enable & ~ss_n_in;
  assign slave_fault  = is_slave & mode_fault_enable & (state_reg == ST_RUN)
                        & ~ss_prev_reg & ss_n_in;

  // control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_irq_enable   <= 1'b0;
      master_select   <= RST_MASTER;
      clock_polarity  <= 1'b0;
      clock_phase     <= RST_PHASE;
      wired_or_select <= 1'b0;
      serial_enable   <= 1'b0;
      tx_irq_enable   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        rx_irq_enable   <= wdata[CTL_RX_IRQ_EN];
        master_select   <= wdata[CTL_MASTER];
        clock_polarity  <= wdata[CTL_POLARITY];
        clock_phase     <= wdata[CTL_PHASE];
        wired_or_select <= wdata[CTL_WIRED_OR];
        serial_enable   <= wdata[CTL_ENABLE];
        tx_irq_enable   <= wdata[CTL_TX_IRQ_EN];
      end
      // a faulted master drops off the bus to avoid a fight with the other master
      if (master_fault)
        serial_enable <= 1'b0;
    end
  end

  // writable half of the status/control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      error_irq_enable  <= 1'b0;
      mode_fault_enable <= 1'b0;
      rate_select_hi    <= 1'b0;
      rate_select_lo    <= 1'b0;
    end else if (wr_sts) begin
      error_irq_enable  <= wdata[STS_ERR_IRQ_EN];
      mode_fault_enable <= wdata[STS_MF_ENABLE];
      rate_select_hi    <= wdata[STS_RATE_HI];
      rate_select_lo    <= wdata[STS_RATE_LO];
    end
  end

  // transmit buffer and its empty flag; a load beats a clear by write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_buf_reg    <= '0;
      tx_empty_flag <= RST_TX_EMPTY;
    end else if (!serial_enable) begin
      tx_empty_flag <= RST_TX_EMPTY;
    end else begin
      if (wr_data) begin
        tx_buf_reg    <= wdata;
        tx_empty_flag <= 1'b0;
      end
      if (load_shift)
        tx_empty_flag <= 1'b1;
    end
  end

  // receive buffer and receive flags; sets win over clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_buf_reg    <= '0;
      rx_full_flag  <= 1'b0;
      overflow_flag <= 1'b0;
      ovr_armed_reg <= 1'b0;
    end else begin
      if (rd_sts && overflow_flag)
        ovr_armed_reg <= 1'b1;
      if (rd_data) begin
        rx_full_flag <= 1'b0;
        if (ovr_armed_reg) begin
          overflow_flag <= 1'b0;
          ovr_armed_reg <= 1'b0;
        end
      end
      if (byte_done) begin
        if (rx_full_flag && !rd_data) begin
          overflow_flag <= 1'b1;
        end else begin
          rx_buf_reg   <= rx_byte;
          rx_full_flag <= 1'b1;
        end
      end
    end
  end

  // mode fault flag, left alone when its enable is cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_fault_flag <= 1'b0;
      mf_armed_reg    <= 1'b0;
    end else begin
      if (rd_sts && mode_fault_flag)
        mf_armed_reg <= 1'b1;
      if (wr_data && mf_armed_reg) begin
        mode_fault_flag <= 1'b0;
        mf_armed_reg    <= 1'b0;
      end
      if (master_fault || slave_fault)
        mode_fault_flag <= 1'b1;
    end
  end

  // transfer state, shifter and edge count
  always_ff @(posedge clk_sys) begin
    if (rst || !serial_enable) begin
      state_reg    <= ST_IDLE;
      edge_cnt_reg <= '0;
      tx_shift_reg <= '0;
      rx_shift_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          edge_cnt_reg <= '0;
          if (load_shift)
            tx_shift_reg <= tx_buf_reg;
          if (start_xfer)
            state_reg <= ST_RUN;
          // phase 1 slave: the starting edge is already the first shift edge
          if (start_xfer && is_slave && clock_phase)
            edge_cnt_reg <= 4'h1;
        end
        ST_RUN: begin
          if (sclk_edge)
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
          if (sample_edge)
            rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], data_bit_in};
          if (shift_edge && edge_cnt_reg != '0)
            tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
          if (byte_done || master_fault || slave_fault)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // master clock divider and level
  always_ff @(posedge clk_sys) begin
    if (rst || !is_master || state_reg != ST_RUN) begin
      div_cnt_reg    <= half_period;
      sclk_level_reg <= clock_polarity;
    end else if (div_tick) begin
      div_cnt_reg    <= half_period;
      sclk_level_reg <= ~sclk_level_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 7'h01;
    end
  end

  // pin history for edge detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      ss_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_in;
      ss_prev_reg   <= ss_n_in;
    end
  end

  // pin drivers, registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_drv_reg <= '0;
      mosi_drv_reg <= '0;
      miso_drv_reg <= '0;
    end else begin
      sclk_drv_reg <= pin_drive(sclk_level_reg, is_master, wired_or_select);
      mosi_drv_reg <= pin_drive(tx_shift_reg[DATA_W-1], is_master, wired_or_select);
      miso_drv_reg <= pin_drive(tx_shift_reg[DATA_W-1], selected, wired_or_select);
    end
  end

  // register read data, valid the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (rst || !rd) begin
      rdata_reg <= '0;
    end else begin
      case (addr)
        OFS_CONTROL: rdata_reg <= {rx_irq_enable, 1'b0, master_select, clock_polarity,
                                   clock_phase, wired_or_select, serial_enable, tx_irq_enable};
        OFS_STATUS:  rdata_reg <= {rx_full_flag, error_irq_enable, overflow_flag, mode_fault_flag,
                                   tx_empty_flag, mode_fault_enable, rate_select_hi, rate_select_lo};
        OFS_DATA:    rdata_reg <= rx_buf_reg;
        default:     rdata_reg <= '0;
      endcase
    end
  end

  // interrupt request
  always_ff @(posedge clk_sys) begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= (rx_full_flag & rx_irq_enable)
               | (tx_empty_flag & tx_irq_enable)
               | (error_irq_enable & (overflow_flag | mode_fault_flag));
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // the arm bit must still be set at the data read, else a later overflow would look cleared
  sequence s_ovr_clear;
    (rd_sts && overflow_flag) ##[1:4] (ovr_armed_reg && rd_data && !byte_done);
  endsequence

  property p_rx_irq;
    rx_full_flag && rx_irq_enable |=> irq_reg;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");

  property p_err_irq;
    error_irq_enable && (overflow_flag || mode_fault_flag) && !wr_sts |=> irq_reg;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error interrupt missing");

  property p_tx_load;
    serial_enable && state_reg == ST_IDLE && wr_data && !master_fault |-> ##[1:2] tx_empty_flag;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("idle load too slow");

  property p_no_load_running;
    state_reg == ST_RUN && serial_enable && !sclk_edge |=> $stable(tx_shift_reg);
  endproperty
  a_no_load_running: assert property (p_no_load_running) else $error("shifter changed mid-byte");

  property p_overflow_keeps;
    byte_done && rx_full_flag && !rd_data |=> overflow_flag && $stable(rx_buf_reg);
  endproperty
  a_overflow_keeps: assert property (p_overflow_keeps) else $error("overflow handling wrong");

  property p_ovr_clear;
    s_ovr_clear |=> !overflow_flag;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overflow not cleared");

  property p_rx_clear;
    rd_data && !byte_done |=> !rx_full_flag;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag not cleared");

  property p_master_fault;
    is_master && mode_fault_enable && !ss_n_in |=> mode_fault_flag && !serial_enable;
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master fault missed");

  property p_deselected_float;
    is_slave && ss_n_in && !wr_ctl |=> !miso_drv_reg.oe;
  endproperty
  a_deselected_float: assert property (p_deselected_float) else $error("slave drives while deselected");

  property p_slave_start;
    is_slave && !clock_phase && state_reg == ST_IDLE && ss_prev_reg && !ss_n_in |=> state_reg == ST_RUN;
  endproperty
  a_slave_start: assert property (p_slave_start) else $error("slave did not start");

  property p_wired_or;
    wired_or_select && !wr_ctl |=> !mosi_drv_reg.out && !sclk_drv_reg.out;
  endproperty
  a_wired_or: assert property (p_wired_or) else $error("open-drain pin driven high");

endmodule // serial_regs

// [dv/serial_peer.sv]
// peer slave model on the serial pins: phase 1, polarity 0, msb first
`timescale 1ns/100ps
module serial_peer (
  // serial pins
  input  wire logic       sel_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso_out,
  output logic            miso_oe,
  // byte exchanged in each frame
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh;
  logic [2:0] cnt = 3'h0;
  // released miso floats; the bench pulls it up
  assign miso_oe = ~sel_n;
  // leading edge launches the next bit
  always @(posedge sclk) begin
    if (!sel_n) begin
      if (cnt == 3'h0) begin
        sh = tx_byte;
      end
      miso_out <= sh[7];
    end
  end
  // trailing edge samples; deselect restarts, so a torn frame never shifts on
  always @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      cnt = 3'h0;
    end else begin
      sh = {sh[6:0], mosi};
      rx_byte <= (cnt == 3'h7) ? sh : rx_byte;
      cnt = cnt + 3'h1;
    end
  end
endmodule // serial_peer

// [dv/serial_regs_bench.sv]
// self-checking bench: register tasks, peer slave, faults and pin checks
`timescale 1ns/100ps
module serial_regs_bench
  import serial_regs_pkg::*;
;
  logic       clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ss_n = 1'b1, peer_sel_n = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, peer_tx = 8'h00;
  logic [7:0] rdata, peer_rx;
  logic       irq, pm_out, pm_oe, sclk_w, mosi_w, miso_w;
  pin_drive_t sclk_d, mosi_d, miso_d;
  int         n_errors = 0, tests_run = 0, n;
  // board pull-ups hold every released line high
  assign sclk_w = sclk_d.oe ? sclk_d.out : 1'b1;
  assign mosi_w = mosi_d.oe ? mosi_d.out : 1'b1;
  assign miso_w = pm_oe ? pm_out : (miso_d.oe ? miso_d.out : 1'b1);
  serial_regs i_serial_regs (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_reg(rdata),
    .irq_reg(irq), .sclk_in(sclk_w), .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_n),
    .sclk_drv_reg(sclk_d), .mosi_drv_reg(mosi_d), .miso_drv_reg(miso_d)
  );
  serial_peer i_serial_peer (
    .sel_n(peer_sel_n), .sclk(sclk_w), .mosi(mosi_w), .miso_out(pm_out), .miso_oe(pm_oe),
    .tx_byte(peer_tx), .rx_byte(peer_rx)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(d & m, e);
  endtask
  // bounded poll of one status flag
  task automatic wait_sts(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 3000 && s[b] !== 1'b1; i++) begin
      rd_reg(OFS_STATUS, s);
    end
  endtask
  // cycles between two serial clock toggles
  task automatic half_period(output int h);
    logic s;
    s = sclk_d.out;
    h = 0;
    for (int i = 0; i < 600 && sclk_d.out === s; i++) begin
      @(posedge clk_sys);
    end
    s = sclk_d.out;
    while (h < 600 && sclk_d.out === s) begin
      @(posedge clk_sys);
      h++;
    end
  endtask
  // irq and pin drives are registered levels: let them land
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    n_errors++;
    $display("[ERR] %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 8'hff, 8'h28);
    rd_chk(OFS_STATUS, 8'hff, 8'h08);
    rd_chk(8'h13, 8'hff, 8'h00);
    $display("test reset values done");
    for (int r = 0; r < 4; r++) begin
      wr_reg(OFS_STATUS, r[7:0]);
      wr_reg(OFS_CONTROL, 8'h2a);
      // enabling pulls the clock line low; select the peer only after that edge
      settle();
      peer_tx    <= 8'h3c + r[7:0];
      peer_sel_n <= 1'b0;
      wr_reg(OFS_DATA, 8'ha5 ^ r[7:0]);
      half_period(n);
      check(n[7:0], 8'h02 << (2 * r));
      wait_sts(STS_RX_FULL);
      rd_chk(OFS_DATA, 8'hff, 8'h3c + r[7:0]);
      check(peer_rx, 8'ha5 ^ r[7:0]);
      peer_sel_n <= 1'b1;
    end
    $display("test master rates done");
    wr_reg(OFS_STATUS, 8'h00);
    peer_sel_n <= 1'b0;
    peer_tx    <= 8'h11;
    wr_reg(OFS_DATA, 8'h5a);
    rd_chk(OFS_STATUS, 8'hff, 8'h08);
    wait_sts(STS_RX_FULL);
    peer_tx <= 8'h22;
    wr_reg(OFS_DATA, 8'hc3);
    wait_sts(STS_OVERFLOW);
    rd_chk(OFS_DATA, 8'hff, 8'h11);
    rd_chk(OFS_STATUS, 8'hff, 8'h08);
    $display("test overflow done");
    wr_reg(OFS_CONTROL, 8'h2b);
    settle();
    check({7'h00, irq}, 8'h01);
    wr_reg(OFS_CONTROL, 8'haa);
    settle();
    check({7'h00, irq}, 8'h00);
    wr_reg(OFS_DATA, 8'h77);
    wait_sts(STS_RX_FULL);
    settle();
    check({7'h00, irq}, 8'h01);
    rd_chk(OFS_DATA, 8'hff, 8'h22);
    settle();
    check({7'h00, irq}, 8'h00);
    peer_sel_n <= 1'b1;
    $display("test interrupts done");
    wr_reg(OFS_STATUS, 8'h44);
    ss_n <= 1'b0;
    settle();
    check({7'h00, irq}, 8'h01);
    rd_chk(OFS_STATUS, 8'hff, 8'h5c);
    rd_chk(OFS_CONTROL, 8'hff, 8'ha8);
    @(posedge clk_sys);
    ss_n <= 1'b1;
    wr_reg(OFS_STATUS, 8'h40);
    rd_chk(OFS_STATUS, 8'h10, 8'h10);
    wr_reg(OFS_DATA, 8'h96);
    rd_chk(OFS_STATUS, 8'h10, 8'h00);
    $display("test mode fault done");
    wr_reg(OFS_CONTROL, 8'h02);
    wr_reg(OFS_DATA, 8'hb4);
    ss_n <= 1'b0;
    settle();
    check({6'h00, miso_d}, 8'h03);
    @(posedge clk_sys);
    ss_n <= 1'b1;
    settle();
    check({7'h00, miso_d.oe}, 8'h00);
    // deselected slave stays mid-byte; partial reset idles it before master checks
    wr_reg(OFS_CONTROL, 8'h00);
    wr_reg(OFS_CONTROL, 8'h26);
    settle();
    check({6'h00, sclk_d}, 8'h01);
    check({7'h00, mosi_d.out}, 8'h00);
    wr_reg(OFS_CONTROL, 8'h36);
    settle();
    check({6'h00, sclk_d}, 8'h00);
    $display("test slave and pins done");
    test_done();
  end
endmodule // serial_regs_bench
